// *** design/irc_pkg.sv ***
/*
 * Constants for the infrared control register block: offsets, field positions,
 * reset values and operating modes.
 * Assumes a classic Wishbone slave on one 250 MHz clock with synchronous reset.
 */
// What this block does
// [RL1] Reset clears the whole control register to zero.
// [RL2] Transmit enable set to one starts sending data held in the FIFO.
// [RL3] Transmit enable written zero stops transmission activity; the code still sends a check sequence and end flag the sender has begun.
// [RL4] Receive enable set to one starts accepting incoming receiver data.
// [RL5] Receive enable written zero moves receiver into receive-ending state.
// [RL6] After end request, next FIFO write is marked as the frame's last byte; the code does not mark a write in the first cycle after the request is set.
// [RL7] After that last byte, check sequence and end flag follow as one frame.
// [RL8] End request clears itself once the terminated frame has been sent.
// [RL9] Software sets threshold to maximum or disables character counter first.
// [RL10] End request is honoured in extended-SIR, MIR, FIR; ignored in SIR.
// [RL11] Bits three to seven store written values and read them back.
package irc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map (byte addresses, one word per register)
    localparam logic [3:0] ADDR_CTRL_ONE  = 4'h4;  // infrared_control_one
    localparam logic [3:0] ADDR_MODE      = 4'h8;  // operating mode select
    localparam logic [3:0] ADDR_STATUS    = 4'hc;  // engine status, read only

    localparam logic [7:0] CTRL_RESET     = 8'h00;

    // Field positions in infrared_control_one
    localparam int TX_EN_BIT   = 0;
    localparam int RX_EN_BIT   = 1;
    localparam int FEND_BIT    = 2;

    // Status word field positions
    localparam int ST_TX_BUSY  = 0;
    localparam int ST_RX_ACT   = 1;
    localparam int ST_RX_END   = 2;
    localparam int ST_LAST_ARM = 3;

    // Operating modes
    typedef enum logic [1:0] {
        IRC_MODE_SIR,
        IRC_MODE_XSIR,
        IRC_MODE_MIR,
        IRC_MODE_FIR
    } irc_mode_e;

    // Frame tail: check sequence bytes then one end flag
    localparam logic [7:0] END_FLAG   = 8'h7e;
    localparam logic [1:0] FCS_BYTES  = 2'h2;
    localparam logic [15:0] FCS_INIT  = 16'hffff;
    localparam logic [15:0] FCS_POLY  = 16'h8408;

endpackage

// *** design/irc_byte_if.sv ***
/*
 * Byte stream carrier between the control core and the frame sender.
 * Assumes both ends share clk_i.
 */
interface irc_byte_if;
    logic       valid;
    logic [7:0] data;
    logic       last;
    logic       ready;
    logic       done;   // Pulse: whole frame tail sent
    logic       plain;  // Byte sent outside any frame

    modport src (output valid, output data, output last, output plain, input ready, input done);
    modport snk (input valid, input data, input last, input plain, output ready, output done);
endinterface

// *** design/irc_tail_sender.sv ***
/*
 * Frame sender: passes payload bytes to the line and, after a byte marked last,
 * appends the check sequence and the end flag.
 * Assumes the line side accepts one byte when line_ready_i is high.
 */
module irc_tail_sender (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Byte stream from core
    irc_byte_if.snk         s,
    // Line side
    output logic            line_valid_o,
    output logic [7:0]      line_data_o,
    input  wire logic       line_ready_i
);

    typedef enum logic [1:0] {SND_DATA, SND_FCS, SND_FLAG} irc_snd_e;

    irc_snd_e    state;
    logic [15:0] fcs;
    logic [1:0]  fcs_cnt;
    logic        flag_on;   // End flag is the byte on the line

    // Bitwise check sequence update over one byte
    function automatic logic [15:0] fcs_next(input logic [15:0] c, input logic [7:0] d);
        logic [15:0] r;
        r = c;
        for (int i = 0; i < 8; i++) begin
            r = (r[0] ^ d[i]) ? ((r >> 1) ^ irc_pkg::FCS_POLY) : (r >> 1);
        end
        return r;
    endfunction

    wire take = line_ready_i || !line_valid_o;

    assign s.ready = (state == SND_DATA) && take;

    // Sequence data, then check bytes, then end flag
    // [RL7] append tail
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state        <= SND_DATA;
            fcs          <= irc_pkg::FCS_INIT;
            fcs_cnt      <= 2'h0;
            line_valid_o <= 1'b0;
            line_data_o  <= 8'h00;
            s.done       <= 1'b0;
            flag_on      <= 1'b0;
        end else begin
            s.done <= 1'b0;
            if (take) begin
                line_valid_o <= 1'b0;
                flag_on      <= 1'b0;
                // [RL8] done once flag left
                if (line_valid_o && flag_on) begin
                    s.done <= 1'b1;
                end
                unique case (state)
                    SND_DATA: if (s.valid) begin
                        line_valid_o <= 1'b1;
                        line_data_o  <= s.data;
                        // Plain bytes leave no stale check state behind
                        fcs          <= s.plain ? irc_pkg::FCS_INIT : fcs_next(fcs, s.data);
                        if (s.last) begin
                            state   <= SND_FCS;
                            fcs_cnt <= 2'h0;
                        end
                    end
                    SND_FCS: begin
                        line_valid_o <= 1'b1;
                        line_data_o  <= (fcs_cnt == 2'h0) ? ~fcs[7:0] : ~fcs[15:8];
                        fcs_cnt      <= fcs_cnt + 2'h1;
                        if (fcs_cnt + 2'h1 == irc_pkg::FCS_BYTES) begin
                            state <= SND_FLAG;
                        end
                    end
                    SND_FLAG: begin
                        line_valid_o <= 1'b1;
                        line_data_o  <= irc_pkg::END_FLAG;
                        fcs          <= irc_pkg::FCS_INIT;
                        state        <= SND_DATA;
                        flag_on      <= 1'b1;
                    end
                endcase
            end
        end
    end

endmodule

// *** design/irc_ctrl.sv ***
/*
 * Infrared control register block: transmit and receive enables and the
 * self-clearing frame end request, behind a classic Wishbone slave.
 * Assumes an external FIFO feeding tx bytes, a receiver on ir_rx_i, one clock.
 */
module irc_ctrl (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o,
    // Transmit FIFO read side
    input  wire logic        txf_valid_i,
    input  wire logic [7:0]  txf_data_i,
    input  wire logic        txf_wr_i,
    output logic             txf_pop_o,
    // Infrared line
    output logic             ir_tx_valid_o,
    output logic [7:0]       ir_tx_data_o,
    input  wire logic        ir_tx_ready_i,
    input  wire logic        ir_rx_i,
    // Receiver control
    output logic             rx_active_o,
    output logic             rx_ending_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0]              ctrl;
    irc_pkg::irc_mode_e      mode;
    logic                    last_armed;
    logic                    tail_pending;
    logic                    wr_pend;
    logic [2:0]              rx_sync;
    logic                    rx_bit;
    logic                    tx_hold_v;
    logic [7:0]              tx_hold_d;
    logic                    tx_hold_l;
    logic                    next_fend_clr;
    // FIFO level counter: holds a level of 0 to 32
    localparam int           LVL_W   = 6;
    localparam logic [LVL_W-1:0] LVL_ONE = 6'h01;
    logic [LVL_W-1:0]        tx_lvl;
    logic [LVL_W-1:0]        tx_ahead;

    irc_byte_if bif ();

    // Framed modes honour the end request
    function automatic logic framed(input irc_pkg::irc_mode_e m);
        return m != irc_pkg::IRC_MODE_SIR;
    endfunction

    wire bus_req  = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire wr_ctrl  = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == irc_pkg::ADDR_CTRL_ONE;
    wire wr_mode  = bus_req && wb_we_i && wb_sel_i[0] && wb_adr_i == irc_pkg::ADDR_MODE;
    wire tx_en    = ctrl[irc_pkg::TX_EN_BIT];
    wire fend     = ctrl[irc_pkg::FEND_BIT];
    wire arm_now  = fend && txf_wr_i && !last_armed && !tail_pending && !wr_pend;

    ////////////////////////////////////////////////////////////////////////////
    // Bus answer: one wait-free ack per request
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h0;
            if (bus_req && !wb_we_i) begin
                unique case (wb_adr_i)
                    irc_pkg::ADDR_CTRL_ONE: wb_dat_o <= {24'h0, ctrl};
                    irc_pkg::ADDR_MODE:     wb_dat_o <= {30'h0, mode};
                    irc_pkg::ADDR_STATUS:   wb_dat_o <= {28'h0, last_armed, rx_ending_o,
                                                         rx_active_o, tail_pending};
                    default:                wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control register; a write setting the end request wins over its hardware clear
    // [RL8] self clear
    assign next_fend_clr = bif.done || (fend && !framed(mode));
    always_ff @(posedge clk_i) begin
        // [RL1] reset zero
        if (rst_i) begin
            ctrl <= irc_pkg::CTRL_RESET;
        end else begin
            // [RL11] upper bits stored
            if (wr_ctrl) begin
                ctrl <= wb_dat_i[7:0];
            end
            // [RL10] ignored in SIR
            if (next_fend_clr && !(wr_ctrl && wb_dat_i[irc_pkg::FEND_BIT])) begin
                ctrl[irc_pkg::FEND_BIT] <= 1'b0;
            end
        end
    end

    // Mode register
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            mode <= irc_pkg::IRC_MODE_SIR;
        end else if (wr_mode) begin
            mode <= irc_pkg::irc_mode_e'(wb_dat_i[1:0]);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Arm on the first FIFO write after the request is set, skipping a write in the very next cycle
    // [RL6] mark next write
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wr_pend    <= 1'b0;
            last_armed <= 1'b0;
        end else begin
            wr_pend <= wr_ctrl && wb_dat_i[irc_pkg::FEND_BIT] && framed(mode);
            if (!fend) begin
                last_armed <= 1'b0;
            end else if (arm_now) begin
                last_armed <= 1'b1;
            end
        end
    end

    // Bytes queued up to the armed one; older bytes leave first
    // [RL6] locate armed byte
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_lvl   <= '0;
            tx_ahead <= '0;
        end else begin
            tx_lvl <= tx_lvl + LVL_W'(txf_wr_i) - LVL_W'(txf_pop_o);
            if (arm_now) begin
                tx_ahead <= tx_lvl + LVL_ONE - LVL_W'(txf_pop_o);
            end else if (txf_pop_o && tx_ahead != '0) begin
                tx_ahead <= tx_ahead - LVL_ONE;
            end
        end
    end

    // FIFO drain into the sender; the armed byte is the last one queued
    // [RL2] send when enabled
    // [RL3] stop when cleared
    assign txf_pop_o = tx_en && txf_valid_i && (!tx_hold_v || bif.ready) && !tail_pending;
    wire pop_last    = txf_pop_o && last_armed && fend && framed(mode) && tx_ahead == LVL_ONE;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_hold_v    <= 1'b0;
            tx_hold_d    <= 8'h00;
            tx_hold_l    <= 1'b0;
            tail_pending <= 1'b0;
        end else begin
            if (bif.ready && bif.valid) begin
                tx_hold_v <= 1'b0;
            end
            if (txf_pop_o) begin
                tx_hold_v <= 1'b1;
                tx_hold_d <= txf_data_i;
                tx_hold_l <= pop_last;
                if (pop_last) begin
                    tail_pending <= 1'b1;
                end
            end
            if (bif.done) begin
                tail_pending <= 1'b0;
            end
        end
    end

    assign bif.valid = tx_hold_v && tx_en;
    assign bif.data  = tx_hold_d;
    assign bif.last  = tx_hold_l;
    assign bif.plain = !framed(mode);

    irc_tail_sender u_sender (
        .clk_i        (clk_i),
        .rst_i        (rst_i),
        .s            (bif),
        .line_valid_o (ir_tx_valid_o),
        .line_data_o  (ir_tx_data_o),
        .line_ready_i (ir_tx_ready_i)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Receiver input: three stages, change accepted when last two agree
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_sync <= 3'h0;
            rx_bit  <= 1'b0;
        end else begin
            rx_sync <= {rx_sync[1:0], ir_rx_i};
            if (rx_sync[1] == rx_sync[2]) begin
                rx_bit <= rx_sync[2];
            end
        end
    end

    // Receiver state
    // [RL4] start receive
    // [RL5] receive ending
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rx_active_o <= 1'b0;
            rx_ending_o <= 1'b0;
        end else begin
            if (ctrl[irc_pkg::RX_EN_BIT]) begin
                rx_active_o <= 1'b1;
                rx_ending_o <= 1'b0;
            end else if (rx_active_o) begin
                rx_active_o <= 1'b0;
                rx_ending_o <= 1'b1;
            end else if (!rx_bit) begin
                rx_ending_o <= 1'b0;  // Line idle: ending complete
            end
        end
    end

endmodule

// *** dv/irc_ctrl_chk.sv ***
/* Assertions on the irc_ctrl ports.
   Assumes a bind from the bench top, one clock and a synchronous reset. */
module irc_ctrl_chk (
    // Clock, reset and bus
    input wire logic        clk_i,
    input wire logic        rst_i,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [3:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Fifo, line and receiver
    input wire logic        txf_valid_i,
    input wire logic        txf_pop_o,
    input wire logic        ir_tx_valid_o,
    input wire logic [7:0]  ir_tx_data_o,
    input wire logic        ir_tx_ready_i,
    input wire logic        rx_active_o,
    input wire logic        rx_ending_o
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    logic acc;
    logic tx_en_m;
    ////////////////////////////////////////////////////////////////////////////
    // Acked access to the control register
    assign acc = wb_cyc_i && wb_stb_i && wb_ack_o && wb_adr_i == 4'h4;
    sequence s_wr;
        acc && wb_we_i && wb_sel_i[0];
    endsequence
    // Transmit enable as software left it; the write lands when the request is taken
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            tx_en_m <= 1'b0;
        end else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == 4'h4) begin
            tx_en_m <= wb_dat_i[0];
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    a_ack_answer: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("request not acked");
    a_ctrl_width: assert property (acc && !wb_we_i |-> wb_dat_o[31:8] == 24'h0)
        else $error("control read wide");
    a_reset_idle: assert property ($fell(rst_i) |-> !ir_tx_valid_o && !rx_active_o && !rx_ending_o)
        else $error("outputs busy after reset");
    a_tx_hold: assert property (ir_tx_valid_o && !ir_tx_ready_i |=> ir_tx_valid_o && $stable(ir_tx_data_o))
        else $error("line byte dropped");
    a_pop_gate: assert property (txf_pop_o |-> txf_valid_i && tx_en_m)
        else $error("pop while empty or off");
    a_rx_start: assert property (s_wr ##0 wb_dat_i[1] |-> ##[1:2] rx_active_o)
        else $error("receiver not started");
    a_rx_end: assert property (s_wr ##0 !wb_dat_i[1] && rx_active_o |-> ##[1:2] rx_ending_o)
        else $error("receiver not ending");
endmodule

// *** dv/irc_line_model.sv ***
/* Line partner: takes bytes in order, stalls when slow_i is high.
   Assumes the bench reads got and drives slow_i. */
module irc_line_model (
    // Clock and reset
    input  wire logic       clk_i,
    input  wire logic       rst_i,
    // Byte handshake and receiver pin
    input  wire logic       slow_i,
    input  wire logic       valid_i,
    input  wire logic [7:0] data_i,
    output logic            ready_o,
    output logic            rx_o
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [7:0] got [$];
    logic [2:0] cnt;
    initial begin
        ready_o = 1'b0;
        rx_o = 1'b1;
    end
    // Accept on handshake; slow mode is ready one cycle in four
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 3'h0;
            ready_o <= 1'b0;
            rx_o <= 1'b1;
        end else begin
            cnt <= cnt + 3'h1;
            ready_o <= !slow_i || cnt[1:0] == 2'h3;
            rx_o <= cnt[2];
            if (valid_i && ready_o) begin
                got.push_back(data_i);
            end
        end
    end
endmodule

// *** dv/testbench.sv ***
/* Bench for irc_ctrl: register rows, frames in every mode, second reset.
   Assumes irc_line_model on the line and a small fifo kept here. */
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    typedef struct {
        logic [3:0]  a;
        logic [31:0] d;
        logic [7:0]  e;
    } irc_row_s;
    logic        clk_i, rst_i, cyc, stb, we, txf_wr, slow, ack, pop, tv, rdy, rx, ra, re;
    logic [3:0]  adr;
    logic [31:0] wd, rd, dat;
    logic [7:0]  td;
    logic [7:0]  fifo [16];
    logic [4:0]  wp, rp;
    int          err_total, n_checks;
    irc_row_s    rows [6] = '{'{4'h4, 32'hf8, 8'hf8}, '{4'h4, 32'h3, 8'h3}, '{4'h4, 32'h1, 8'h1},
                              '{4'h8, 32'h3, 8'h3}, '{4'h0, 32'h5a, 8'h0}, '{4'h4, 32'h0, 8'h0}};
    irc_ctrl u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i(wd), .wb_dat_o(dat), .wb_ack_o(ack),
        .txf_valid_i(wp != rp), .txf_data_i(fifo[rp[3:0]]), .txf_wr_i(txf_wr), .txf_pop_o(pop),
        .ir_tx_valid_o(tv), .ir_tx_data_o(td), .ir_tx_ready_i(rdy), .ir_rx_i(rx),
        .rx_active_o(ra), .rx_ending_o(re));
    irc_line_model u_line (.clk_i(clk_i), .rst_i(rst_i), .slow_i(slow), .valid_i(tv),
        .data_i(td), .ready_o(rdy), .rx_o(rx));
    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // Fifo read side follows the pop strobe
    always @(posedge clk_i) begin
        if (pop && wp != rp) begin
            rp <= rp + 5'h1;
        end
    end
    ////////////////////////////////////////////////////////////////////////////
    task automatic end_sim;
        $display("checks %0d mismatches %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic tmo;
        err_total++;
        end_sim;
    endtask
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask
    // One classic bus cycle, held until ack
    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
        int k;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wd <= d;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (ack !== 1'b1 && k < 50);
        if (k >= 50) tmo;
        r = dat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    // Write strobe first; the byte enters the fifo at the edge that samples it
    task automatic push(input logic [7:0] b);
        @(posedge clk_i);
        txf_wr <= 1'b1;
        @(posedge clk_i);
        fifo[wp[3:0]] <= b;
        wp <= wp + 5'h1;
        txf_wr <= 1'b0;
    endtask
    // Mode, n-1 bytes, request, final byte, enable, then the expected frame on the line
    task automatic frame(input logic [1:0] m, input int n);
        logic [15:0] c;
        logic [7:0]  x [$];
        int          k;
        c = irc_pkg::FCS_INIT;
        slow <= m[0];
        for (k = 0; k < n; k++) begin
            x.push_back(8'h80 + 8'(k));
            c = c ^ {8'h0, x[k]};
            repeat (8) c = c[0] ? (c >> 1) ^ irc_pkg::FCS_POLY : c >> 1;
        end
        wb(1'b1, 4'h8, {30'h0, m}, rd);
        // All but the final byte are queued ahead of the request
        for (k = 0; k < n - 1; k++) push(x[k]);
        wb(1'b1, 4'h4, 32'h4, rd); // transmit enable kept at zero
        wb(1'b0, 4'h4, 32'h0, rd);
        chk("armed", (m == 2'h0) ? 8'h0 : 8'h4, rd[7:0]);
        push(x[n - 1]);
        if (m != 2'h0) begin
            x.push_back(~c[7:0]);
            x.push_back(~c[15:8]);
            x.push_back(irc_pkg::END_FLAG);
        end
        wb(1'b1, 4'h4, 32'h5, rd);
        for (k = 0; u_line.got.size() < x.size(); k++) begin
            @(negedge clk_i);
            if (k > 2000) tmo;
        end
        rd = 32'h4;
        for (k = 0; rd[2] === 1'b1; k++) begin
            wb(1'b0, 4'h4, 32'h0, rd);
            if (k > 20) tmo;
        end
        chk("ctrl_done", 8'h1, rd[7:0]);
        chk("count", 8'(x.size()), 8'(u_line.got.size()));
        foreach (x[i]) chk("byte", x[i], u_line.got[i]);
        wb(1'b1, 4'h4, 32'h0, rd);
        u_line.got.delete();
        $display("test frame mode %0d done", m);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        {cyc, stb, we, txf_wr, slow, adr, wd, wp, rp} = '0;
        err_total = 0;
        n_checks = 0;
        rst_i = 1'b1;
        repeat (12) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 4'h4, 32'h0, rd);
        chk("ctrl_reset", 8'h0, rd[7:0]);
        $display("test reset done");
        foreach (rows[i]) begin
            wb(1'b1, rows[i].a, rows[i].d, rd);
            wb(1'b0, rows[i].a, 32'h0, rd);
            chk("reg_row", rows[i].e, rd[7:0]);
        end
        $display("test rows done");
        for (int m = 0; m < 4; m++) frame(2'(m), m + 1);
        wb(1'b1, 4'h4, 32'h0b, rd);
        rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        rst_i <= 1'b0;
        wb(1'b0, 4'h4, 32'h0, rd);
        chk("ctrl_rereset", 8'h0, rd[7:0]);
        $display("test second reset done");
        end_sim;
    end
endmodule
bind irc_ctrl irc_ctrl_chk u_chk (.*);
